// >>> hdl/scf_consts.svh
`ifndef SCF_CONSTS_SVH
`define SCF_CONSTS_SVH

// clock and link timing
`define SCF_CLK_PERIOD_NS 50
`define SCF_WAKE_LOW_NS 60000
`define SCF_WAKE_CYCLES ((`SCF_WAKE_LOW_NS + `SCF_CLK_PERIOD_NS - 1) / `SCF_CLK_PERIOD_NS)
`define SCF_TIMEOUT_US 1000
`define SCF_WATCHDOG_MS 1000

// block framing
`define SCF_MIN_COUNT 8'h04
`define SCF_MAX_COUNT 8'h54
`define SCF_CMD_MIN_COUNT 8'h07
`define SCF_LEN_READ 8'h07
`define SCF_LEN_WRITE4 8'h0B
`define SCF_LEN_WRITE32 8'h27
`define SCF_LEN_WRITE_MAC 8'h20
`define SCF_STATUS_LEN 8'h04
`define SCF_REV_LEN 8'h07
`define SCF_CRC_POLY 16'h8005
`define SCF_CRC_INIT 16'h0000
`define SCF_LAST_IDX 7'h53

// command codes
`define SCF_OP_PAUSE 8'h01
`define SCF_OP_READ 8'h02
`define SCF_OP_DIGEST_RESP 8'h08
`define SCF_OP_KEYED_RESP 8'h11
`define SCF_OP_WRITE 8'h12
`define SCF_OP_DIGEST_GEN 8'h15
`define SCF_OP_SEED 8'h16
`define SCF_OP_FREEZE 8'h17
`define SCF_OP_RANDOM 8'h1B
`define SCF_OP_KEY_DERIVE 8'h1C
`define SCF_OP_EXTRA_UPD 8'h20
`define SCF_OP_MAC_VERIFY 8'h28
`define SCF_OP_REV_QUERY 8'h30

// one-byte status and error codes
`define SCF_ST_OK 8'h00
`define SCF_ST_MISCOMPARE 8'h01
`define SCF_ST_PARSE 8'h03
`define SCF_ST_EXEC 8'h0F
`define SCF_ST_AWAKE 8'h11
`define SCF_ST_COMM 8'hFF

`endif

// >>> hdl/scf_pkg.sv
`default_nettype none
package scf_pkg;

   typedef enum logic [2:0] {
      ST_SLEEP,
      ST_IDLE,
      ST_LISTEN,
      ST_RECV,
      ST_CHECK,
      ST_EXEC,
      ST_BUILD
   } scf_state_e;

   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] first_argument;
      logic [15:0] second_argument;
   } scf_cmd_s;

   typedef struct packed {
      logic lclk;
      logic data;
      logic rd;
      logic two_wire;
      logic cfg_locked;
      logic [7:0] selector;
   } scf_pins_s;

endpackage : scf_pkg
`default_nettype wire

// >>> hdl/scf_front_end.sv
// How it works
// - packet: command byte 0, first argument byte 1, second argument bytes 2-3, data after
// - last byte of a block received: go busy and try the command
// - busy: nothing readable, all link data transitions ignored
// - single-wire: incomplete block sleeps after the idle timeout
// - two-wire: incomplete block waits until watchdog or start/stop condition
// - wrong block size for a read or write, or under 7 bytes: no execution, error block instead
// - every answer is count, packet, two CRC bytes, from one output buffer
// - after wake and before any command the buffer holds status 0x11
// - CRC or link fault answers 0xFF first, nothing parsed or run
// - parse errors take precedence over execution errors
// - success without longer result returns 0x00 in four bytes
// - MAC verification mismatch returns 0x01
// - illegal length, code or arguments return 0x03
// - command impossible in current state returns 0x0F
// - 0x11 keyed-hash, 0x08 digest response, 0x28 MAC verification
// - 0x02 word read, 0x12 write of 4 or 32 bytes, 0x17 zone freeze
// - 0x1B random, 0x16 seed generation, 0x15 digest generation
// - 0x1C key derivation, 0x30 revision query returning revision bytes
// - 0x01 idles only the addressed device on a shared bus
// - 0x20 updates configuration byte 84 or 85, only once config is locked
// - CRC-16 poly 0x8005, init zero, over count and packet, low byte first
`timescale 1ns/1ps
`default_nettype none
`include "scf_consts.svh"

module scf_front_end #(
   parameter int unsigned TIMEOUT_CYCLES = `SCF_TIMEOUT_US * 1000 / `SCF_CLK_PERIOD_NS,
   parameter int unsigned WATCHDOG_CYCLES = `SCF_WATCHDOG_MS * 1000000 / `SCF_CLK_PERIOD_NS,
   // revision word: arbitrary value
   parameter logic [31:0] REV_WORD = 32'h0A0B0C0D
)(
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic LINK_CLK,
   input wire logic LINK_DATA_IN,
   output logic LINK_DATA_OUT,
   output logic LINK_DATA_OE,
   input wire logic LINK_READ,
   input wire logic TWO_WIRE_MODE,
   input wire logic CONFIG_LOCKED,
   input wire logic [7:0] BUS_SELECTOR,
   output logic EXEC_START,
   output scf_pkg::scf_cmd_s EXEC_CMD,
   input wire logic EXEC_DONE,
   input wire logic [7:0] EXEC_CODE,
   output logic AWAKE,
   output logic BUSY
);

   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      logic fb;
      r = c;
      for (int i = 0; i < 8; i++)
      begin
         fb = d[i] ^ r[15];
         r = {r[14:0], 1'b0};
         if (fb)
            r = r ^ `SCF_CRC_POLY;
      end
      return r;
   endfunction : crc_byte

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and link edge detection
   scf_pkg::scf_pins_s pins_raw;
   scf_pkg::scf_pins_s sync1_reg;
   scf_pkg::scf_pins_s sync2_reg;
   logic prev_clk_reg;
   logic prev_data_reg;

   assign pins_raw = '{lclk: LINK_CLK, data: LINK_DATA_IN, rd: LINK_READ,
      two_wire: TWO_WIRE_MODE, cfg_locked: CONFIG_LOCKED, selector: BUS_SELECTOR};

   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         prev_clk_reg <= 1'b0;
         prev_data_reg <= 1'b1;
      end
      else
      begin
         sync1_reg <= pins_raw;
         sync2_reg <= sync1_reg;
         prev_clk_reg <= sync2_reg.lclk;
         prev_data_reg <= sync2_reg.data;
      end
   end

   wire lclk_rise = sync2_reg.lclk & ~prev_clk_reg;
   // data moving while the link clock is high marks a start or stop condition
   wire start_stop = sync2_reg.lclk & prev_clk_reg & (sync2_reg.data ^ prev_data_reg);

   ////////////////////////////////////////////////////////////////////////////
   // state and decode
   scf_pkg::scf_state_e state_reg;
   logic [7:0] in_mem [0:83];
   logic [7:0] out_mem [0:83];
   logic [7:0] rx_shift_reg;
   logic [2:0] rx_bit_reg;
   logic [6:0] rx_idx_reg;
   logic [7:0] cnt_reg;
   logic [6:0] wk_reg;
   logic [15:0] crc_reg;
   logic [7:0] resp_code_reg;
   logic resp_rev_reg;
   logic [15:0] low_cnt_reg;
   logic [31:0] tmo_reg;
   logic [31:0] wdg_reg;
   logic [6:0] tx_idx_reg;
   logic [2:0] tx_bit_reg;
   logic drive_low_reg;
   logic exec_start_reg;
   scf_pkg::scf_cmd_s exec_cmd_reg;

   wire st_sleepy = (state_reg == scf_pkg::ST_SLEEP) || (state_reg == scf_pkg::ST_IDLE);
   wire st_rx = (state_reg == scf_pkg::ST_LISTEN) || (state_reg == scf_pkg::ST_RECV);
   wire busy_w = (state_reg == scf_pkg::ST_CHECK) || (state_reg == scf_pkg::ST_EXEC)
      || (state_reg == scf_pkg::ST_BUILD);
   // a read request in the middle of a block is not honoured
   wire bit_take = st_rx && lclk_rise && (!sync2_reg.rd || state_reg == scf_pkg::ST_RECV);
   wire [7:0] byte_val = {rx_shift_reg[6:0], sync2_reg.data};
   wire byte_done = bit_take && (rx_bit_reg == 3'h7);
   wire [7:0] rx_count = (rx_idx_reg == 7'h00) ? byte_val : in_mem[0];
   wire [7:0] rx_next = {1'b0, rx_idx_reg} + 8'h01;
   wire rx_complete = byte_done && (rx_next >= rx_count || rx_next == `SCF_MAX_COUNT);
   wire rx_abort = (state_reg == scf_pkg::ST_RECV) && sync2_reg.two_wire && start_stop;

   wire wake_hit = st_sleepy && !sync2_reg.data
      && (low_cnt_reg == 16'(`SCF_WAKE_CYCLES - 1));
   wire tmo_expire = (state_reg == scf_pkg::ST_RECV) && !sync2_reg.two_wire
      && (tmo_reg == TIMEOUT_CYCLES - 1);
   wire wdg_expire = !st_sleepy && (wdg_reg == WATCHDOG_CYCLES - 1);

   // command fields sit after the count byte
   scf_pkg::scf_cmd_s cmd_w;
   assign cmd_w = '{opcode: in_mem[1], first_argument: in_mem[2],
      second_argument: {in_mem[4], in_mem[3]}};

   wire op_known = cmd_w.opcode inside {`SCF_OP_KEYED_RESP, `SCF_OP_DIGEST_RESP,
      `SCF_OP_MAC_VERIFY, `SCF_OP_READ, `SCF_OP_WRITE, `SCF_OP_FREEZE, `SCF_OP_RANDOM,
      `SCF_OP_SEED, `SCF_OP_DIGEST_GEN, `SCF_OP_KEY_DERIVE, `SCF_OP_REV_QUERY,
      `SCF_OP_PAUSE, `SCF_OP_EXTRA_UPD};
   wire len_read_bad = (cmd_w.opcode == `SCF_OP_READ) && (cnt_reg != `SCF_LEN_READ);
   wire len_write_bad = (cmd_w.opcode == `SCF_OP_WRITE) && !(cnt_reg inside {`SCF_LEN_WRITE4,
      `SCF_LEN_WRITE32, `SCF_LEN_WRITE4 + `SCF_LEN_WRITE_MAC,
      `SCF_LEN_WRITE32 + `SCF_LEN_WRITE_MAC});
   wire parse_err = !op_known || (cnt_reg < `SCF_CMD_MIN_COUNT) || len_read_bad
      || len_write_bad;
   wire upd_locked_bad = (cmd_w.opcode == `SCF_OP_EXTRA_UPD) && !sync2_reg.cfg_locked;
   wire is_pause = cmd_w.opcode == `SCF_OP_PAUSE;
   wire pause_me = is_pause && (cmd_w.first_argument == sync2_reg.selector);
   wire is_rev = cmd_w.opcode == `SCF_OP_REV_QUERY;

   wire cnt_bad = (cnt_reg < `SCF_MIN_COUNT) || (cnt_reg > `SCF_MAX_COUNT);
   wire wk_at_crc = ({1'b0, wk_reg} == cnt_reg - 8'h02);
   wire [15:0] rx_crc = {in_mem[wk_reg + 7'h01], in_mem[wk_reg]};
   wire comm_bad = cnt_bad || (wk_at_crc && (rx_crc != crc_reg));
   wire chk_end = (state_reg == scf_pkg::ST_CHECK) && (cnt_bad || wk_at_crc);

   wire [7:0] resp_len = resp_rev_reg ? `SCF_REV_LEN : `SCF_STATUS_LEN;
   wire [7:0] wk8 = {1'b0, wk_reg};
   wire [6:0] wk_m1 = wk_reg - 7'h01;
   wire [7:0] rev_byte = REV_WORD[{wk_m1[1:0], 3'b000} +: 8];
   wire [7:0] build_byte = (wk_reg == 7'h00) ? resp_len
      : (wk8 == resp_len - 8'h02) ? crc_reg[7:0]
      : (wk8 == resp_len - 8'h01) ? crc_reg[15:8]
      : resp_rev_reg ? rev_byte : resp_code_reg;
   wire build_last = (state_reg == scf_pkg::ST_BUILD) && (wk8 == resp_len - 8'h01);
   wire build_crc = wk8 < resp_len - 8'h02;
   wire [7:0] crc_in = (state_reg == scf_pkg::ST_CHECK) ? in_mem[wk_reg] : build_byte;

   ////////////////////////////////////////////////////////////////////////////
   // control sequence
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         state_reg <= scf_pkg::ST_SLEEP;
         cnt_reg <= 8'h00;
         wk_reg <= 7'h00;
         crc_reg <= `SCF_CRC_INIT;
         resp_code_reg <= `SCF_ST_OK;
         resp_rev_reg <= 1'b0;
         exec_start_reg <= 1'b0;
         exec_cmd_reg <= '0;
      end
      else
      begin
         exec_start_reg <= 1'b0;
         // expired timers win over everything, even a running command
         if (wdg_expire || tmo_expire)
            state_reg <= scf_pkg::ST_SLEEP;
         else
         begin
            case (state_reg)
               scf_pkg::ST_SLEEP, scf_pkg::ST_IDLE:
                  if (wake_hit)
                  begin
                     state_reg <= scf_pkg::ST_BUILD;
                     resp_code_reg <= `SCF_ST_AWAKE;
                     resp_rev_reg <= 1'b0;
                     wk_reg <= 7'h00;
                     crc_reg <= `SCF_CRC_INIT;
                  end
               scf_pkg::ST_LISTEN:
                  if (bit_take)
                     state_reg <= scf_pkg::ST_RECV;
               scf_pkg::ST_RECV:
                  if (rx_abort)
                     state_reg <= scf_pkg::ST_LISTEN;
                  else if (rx_complete)
                  begin
                     state_reg <= scf_pkg::ST_CHECK;
                     cnt_reg <= rx_count;
                     wk_reg <= 7'h00;
                     crc_reg <= `SCF_CRC_INIT;
                  end
               scf_pkg::ST_CHECK:
                  if (chk_end)
                  begin
                     wk_reg <= 7'h00;
                     crc_reg <= `SCF_CRC_INIT;
                     resp_rev_reg <= 1'b0;
                     state_reg <= scf_pkg::ST_BUILD;
                     if (comm_bad)
                        resp_code_reg <= `SCF_ST_COMM;
                     else if (parse_err)
                        resp_code_reg <= `SCF_ST_PARSE;
                     else if (upd_locked_bad)
                        resp_code_reg <= `SCF_ST_EXEC;
                     else if (pause_me)
                        state_reg <= scf_pkg::ST_IDLE;
                     else if (is_pause)
                        resp_code_reg <= `SCF_ST_OK;
                     else if (is_rev)
                        resp_rev_reg <= 1'b1;
                     else
                     begin
                        state_reg <= scf_pkg::ST_EXEC;
                        exec_start_reg <= 1'b1;
                        exec_cmd_reg <= cmd_w;
                     end
                  end
                  else
                  begin
                     crc_reg <= crc_byte(crc_reg, crc_in);
                     wk_reg <= wk_reg + 7'h01;
                  end
               scf_pkg::ST_EXEC:
                  if (EXEC_DONE)
                  begin
                     // datapath code carries 0x00, 0x01, 0x03 or 0x0F
                     resp_code_reg <= EXEC_CODE;
                     state_reg <= scf_pkg::ST_BUILD;
                     wk_reg <= 7'h00;
                     crc_reg <= `SCF_CRC_INIT;
                  end
               scf_pkg::ST_BUILD:
                  if (build_last)
                     state_reg <= scf_pkg::ST_LISTEN;
                  else
                  begin
                     if (build_crc)
                        crc_reg <= crc_byte(crc_reg, crc_in);
                     wk_reg <= wk_reg + 7'h01;
                  end
               default:
                  state_reg <= scf_pkg::ST_SLEEP;
            endcase
         end
      end
   end

   // shared output buffer for status, error and result blocks
   always_ff @(posedge MCLK)
   begin
      if (state_reg == scf_pkg::ST_BUILD)
         out_mem[wk_reg] <= build_byte;
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive shifter, msb first, sampled on link clock rise
   always_ff @(posedge MCLK)
   begin
      if (byte_done)
         in_mem[rx_idx_reg] <= byte_val;
   end

   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         rx_shift_reg <= 8'h00;
         rx_bit_reg <= 3'h0;
         rx_idx_reg <= 7'h00;
      end
      else if (state_reg != scf_pkg::ST_RECV && !bit_take)
      begin
         rx_bit_reg <= 3'h0;
         rx_idx_reg <= 7'h00;
      end
      else if (bit_take)
      begin
         rx_shift_reg <= byte_val;
         rx_bit_reg <= rx_bit_reg + 3'h1;
         if (byte_done && rx_idx_reg != `SCF_LAST_IDX)
            rx_idx_reg <= rx_idx_reg + 7'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // timers: wake detect, idle timeout, watchdog
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         low_cnt_reg <= 16'h0000;
         tmo_reg <= 32'h00000000;
         wdg_reg <= 32'h00000000;
      end
      else
      begin
         low_cnt_reg <= (st_sleepy && !sync2_reg.data && !wake_hit) ? low_cnt_reg + 16'h0001
            : 16'h0000;
         tmo_reg <= (state_reg == scf_pkg::ST_RECV && !bit_take) ? tmo_reg + 32'h00000001
            : 32'h00000000;
         wdg_reg <= st_sleepy ? 32'h00000000 : wdg_reg + 32'h00000001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit: open-drain, output block replays from its start when finished
   wire tx_active = (state_reg == scf_pkg::ST_LISTEN) && sync2_reg.rd;
   wire [7:0] tx_byte = out_mem[tx_idx_reg];
   wire tx_byte_end = (tx_bit_reg == 3'h7);
   wire tx_wrap = {1'b0, tx_idx_reg} + 8'h01 >= out_mem[0];

   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         tx_idx_reg <= 7'h00;
         tx_bit_reg <= 3'h0;
         drive_low_reg <= 1'b0;
      end
      else
      begin
         drive_low_reg <= tx_active && !tx_byte[~tx_bit_reg];
         if (state_reg != scf_pkg::ST_LISTEN)
         begin
            tx_idx_reg <= 7'h00;
            tx_bit_reg <= 3'h0;
         end
         else if (tx_active && lclk_rise)
         begin
            tx_bit_reg <= tx_bit_reg + 3'h1;
            if (tx_byte_end)
               tx_idx_reg <= tx_wrap ? 7'h00 : tx_idx_reg + 7'h01;
         end
      end
   end

   assign LINK_DATA_OUT = 1'b0;
   assign LINK_DATA_OE = drive_low_reg;
   assign EXEC_START = exec_start_reg;
   assign EXEC_CMD = exec_cmd_reg;
   assign AWAKE = !st_sleepy;
   assign BUSY = busy_w;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RSTN);

   a_busy_no_drive: assert property (busy_w |-> ##1 !LINK_DATA_OE)
      else $error("link driven while busy");
   a_complete_busy: assert property (rx_complete && !rx_abort && !wdg_expire && !tmo_expire
      |=> state_reg == scf_pkg::ST_CHECK)
      else $error("complete block did not start processing");
   a_wake_status: assert property (wake_hit && !wdg_expire |=> resp_code_reg == `SCF_ST_AWAKE
      ##4 state_reg == scf_pkg::ST_LISTEN && out_mem[1] == `SCF_ST_AWAKE)
      else $error("wake status block missing");
   a_comm_first: assert property (chk_end && comm_bad && !wdg_expire
      |=> resp_code_reg == `SCF_ST_COMM && !EXEC_START)
      else $error("link fault not reported first");
   a_parse_noexec: assert property (chk_end && !comm_bad && parse_err && !wdg_expire
      |=> resp_code_reg == `SCF_ST_PARSE && state_reg == scf_pkg::ST_BUILD)
      else $error("bad command was executed");
   a_timeout_sleep: assert property (tmo_expire |=> state_reg == scf_pkg::ST_SLEEP)
      else $error("idle timeout ignored");
   a_abort_listen: assert property (rx_abort && !wdg_expire
      |=> state_reg == scf_pkg::ST_LISTEN)
      else $error("start or stop did not end block");
   a_two_wire_wait: assert property (state_reg == scf_pkg::ST_RECV && sync2_reg.two_wire
      && !bit_take && !start_stop && !wdg_expire |=> state_reg == scf_pkg::ST_RECV)
      else $error("two-wire block abandoned early");
   a_upd_locked: assert property (chk_end && !comm_bad && !parse_err && upd_locked_bad
      && !wdg_expire |=> resp_code_reg == `SCF_ST_EXEC)
      else $error("extra update ran while unlocked");
   a_block_frame: assert property (build_last && !wdg_expire
      |=> out_mem[0] == $past(resp_len) && out_mem[$past(wk_reg)] == $past(crc_reg[15:8]))
      else $error("output block badly framed");
   a_exec_pulse: assert property (EXEC_START |=> !EXEC_START [*2])
      else $error("command started twice");

   c_wake: cover property (wake_hit ##[1:20] state_reg == scf_pkg::ST_LISTEN);
   c_exec_done: cover property (state_reg == scf_pkg::ST_EXEC ##[1:200] EXEC_DONE);
   c_comm_err: cover property (chk_end && comm_bad);
   c_pause: cover property (chk_end && pause_me);

endmodule : scf_front_end

`default_nettype wire

// >>> test/scf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module scf_host_model (
   input wire logic mclk,
   input wire logic oe,
   output logic lclk,
   output logic rd,
   output logic dline
);
   logic drv = 1'b1;
   // open-drain line with pull-up: low while either side pulls
   assign dline = drv & ~oe;
   initial
   begin
      lclk = 1'b0;
      rd = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge mclk);
   endtask : hold
   task automatic wake();
      drv = 1'b0;
      hold(1300);
      drv = 1'b1;
      hold(20);
   endtask : wake
   // data moves only while the link clock is low, so two-wire never sees an abort
   task automatic put_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         drv = b[i];
         hold(4);
         lclk = 1'b1;
         hold(4);
         lclk = 1'b0;
      end
   endtask : put_byte
   // one stray bit plus a read request, used while the device is busy
   task automatic poke();
      rd = 1'b1;
      drv = 1'b0;
      hold(2);
      lclk = 1'b1;
      hold(2);
      lclk = 1'b0;
      drv = 1'b1;
      rd = 1'b0;
   endtask : poke
   // data moves while the link clock is high: a start or stop condition
   task automatic stop_cond();
      lclk = 1'b1;
      hold(4);
      drv = ~drv;
      hold(4);
      lclk = 1'b0;
      drv = 1'b1;
   endtask : stop_cond
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      logic fb;
      c = 16'h0000;
      foreach (q[i])
         for (int b = 0; b < 8; b++)
         begin
            fb = c[15] ^ q[i][b];
            c = {c[14:0], 1'b0} ^ (fb ? 16'h8005 : 16'h0000);
         end
      return c;
   endfunction : crc16
   task automatic send_block(input logic [7:0] pk[$], input bit bad);
      logic [7:0] q[$];
      logic [15:0] c;
      q = {8'(pk.size() + 3), pk};
      c = crc16(q) ^ {15'h0000, bad};
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      // the whole block goes out before any read is tried
      foreach (q[i])
         put_byte(q[i]);
      drv = 1'b1;
   endtask : send_block
   task automatic get_byte(output logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         b[i] = dline;
         lclk = 1'b1;
         hold(4);
         lclk = 1'b0;
         hold(4);
      end
   endtask : get_byte
   task automatic get_block(output logic [7:0] q[$]);
      logic [7:0] b;
      int n;
      q = {};
      rd = 1'b1;
      hold(8);
      get_byte(b);
      q.push_back(b);
      // a corrupt count must not hang the read
      n = (b >= 8'h04 && b <= 8'h54) ? b : 4;
      repeat (n - 1)
      begin
         get_byte(b);
         q.push_back(b);
      end
      rd = 1'b0;
      hold(4);
   endtask : get_block
endmodule : scf_host_model
`default_nettype wire

// >>> test/secure_chip_command_front_end_tb.sv
`timescale 1ns/1ps
`default_nettype none
module secure_chip_command_front_end_tb;
   localparam int TO = 50;
   localparam int WD = 40000;
   localparam logic [31:0] REV = 32'h0A0B0C0D;
   localparam logic [7:0] OPS [11] = '{8'h11, 8'h08, 8'h28, 8'h02, 8'h12, 8'h12, 8'h17,
      8'h1B, 8'h16, 8'h15, 8'h1C};
   localparam int LENS [11] = '{7, 7, 7, 7, 11, 39, 7, 7, 7, 7, 7};
   localparam logic [7:0] CODES [4] = '{8'h00, 8'h01, 8'h03, 8'h0F};
   logic mclk = 1'b0;
   logic rstn, lclk, rd, dline, oe, two_wire, locked, exec_start, exec_done, awake, busy, dout;
   logic [31:0] seed_keep;
   logic [7:0] sel, exec_code, dp_code;
   logic [7:0] none[$];
   logic [31:0] seed = 32'h569F11C7;
   scf_pkg::scf_cmd_s exec_cmd, cmd_seen;
   int error_cnt = 0;
   int samples_checked = 0;
   int n_start = 0;
   always #25 mclk = ~mclk;
   scf_host_model i_host (.mclk(mclk), .oe(oe), .lclk(lclk), .rd(rd), .dline(dline));
   scf_front_end #(.TIMEOUT_CYCLES(TO), .WATCHDOG_CYCLES(WD), .REV_WORD(REV)) i_dut (
      .MCLK(mclk), .RSTN(rstn), .LINK_CLK(lclk), .LINK_DATA_IN(dline), .LINK_DATA_OUT(dout),
      .LINK_DATA_OE(oe), .LINK_READ(rd), .TWO_WIRE_MODE(two_wire), .CONFIG_LOCKED(locked),
      .BUS_SELECTOR(sel), .EXEC_START(exec_start), .EXEC_CMD(exec_cmd),
      .EXEC_DONE(exec_done), .EXEC_CODE(exec_code), .AWAKE(awake), .BUSY(busy));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : give_verdict
   // reference block: count, packet, crc low, crc high
   task automatic expect_block(input logic [7:0] pk[$]);
      logic [7:0] e[$];
      logic [7:0] r[$];
      logic [15:0] c;
      e = {8'(pk.size() + 3), pk};
      c = i_host.crc16(e);
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
      i_host.get_block(r);
      chk("block length", e.size(), r.size());
      foreach (e[i])
         chk("block byte", e[i], r[i]);
   endtask : expect_block
   task automatic wait_flag(input logic want, ref logic flag, input int lim);
      int n;
      n = 0;
      while (flag !== want && n < lim)
      begin
         @(negedge mclk);
         n++;
      end
   endtask : wait_flag
   task automatic cmd(input logic [7:0] op, input int len, input logic [7:0] a1,
      input bit bad, input bit dp, input logic [7:0] ans[$]);
      logic [7:0] pk[$];
      logic [15:0] a2;
      int s;
      a2 = 16'(rnd());
      pk = {op, a1, a2[7:0], a2[15:8]};
      while (pk.size() < len - 3)
         pk.push_back(8'(rnd()));
      dp_code = ans[0];
      s = n_start;
      i_host.send_block(pk, bad);
      wait_flag(1'b1, busy, 40);
      chk("busy raised", 1, busy);
      if (dp)
      begin
         i_host.poke();
         chk("output while busy", 0, oe);
      end
      wait_flag(1'b0, busy, 400);
      chk("busy dropped", 0, busy);
      chk("exec starts", s + dp, n_start);
      if (dp)
         chk("exec command", {op, a1, a2}, cmd_seen);
      if (ans.size() > 0)
         expect_block(ans);
   endtask : cmd
   ////////////////////////////////////////////////////////////////////////////////
   // datapath stand-in; the delay is long enough for a stray bit to land while busy
   initial
   begin
      exec_done = 1'b0;
      exec_code = 8'h00;
      forever
      begin
         @(posedge exec_start);
         n_start++;
         cmd_seen = exec_cmd;
         repeat (12 + rnd() % 32) @(negedge mclk);
         exec_code = dp_code;
         exec_done = 1'b1;
         @(negedge mclk);
         exec_done = 1'b0;
      end
   end
   initial
   begin
      repeat (100000) @(posedge mclk);
      error_cnt++;
      give_verdict();
   end
   initial
   begin
      rstn = 1'b0;
      dp_code = 8'h00;
      two_wire = 1'b1;
      locked = 1'b0;
      sel = 8'h5A;
      repeat (4) @(negedge mclk);
      rstn = 1'b1;
      repeat (4) @(negedge mclk);
      chk("asleep after reset", 0, awake);
      chk("data out value", 0, dout);
      i_host.wake();
      chk("awake", 1, awake);
      expect_block('{8'h11});
      for (int i = 0; i < 11; i++)
         cmd(OPS[i], LENS[i], 8'(rnd()), 0, 1, '{CODES[i % 4]});
      seed_keep = seed;
      cmd(8'h55, 7, 8'h00, 1, 0, '{8'hFF});
      seed = seed_keep;
      cmd(8'h55, 7, 8'h00, 0, 0, '{8'h03});
      cmd(8'h02, 8, 8'h00, 0, 0, '{8'h03});
      cmd(8'h12, 12, 8'h00, 0, 0, '{8'h03});
      cmd(8'h20, 7, 8'h00, 0, 0, '{8'h0F});
      locked = 1'b1;
      cmd(8'h20, 7, 8'h00, 0, 1, '{8'h00});
      cmd(8'h30, 7, 8'h00, 0, 0, '{REV[7:0], REV[15:8], REV[23:16], REV[31:24]});
      cmd(8'h01, 7, ~sel, 0, 0, '{8'h00});
      cmd(8'h01, 7, sel, 0, 0, none);
      chk("idle after own pause", 0, awake);
      i_host.wake();
      expect_block('{8'h11});
      i_host.put_byte(8'h07);
      i_host.stop_cond();
      cmd(8'h01, 7, ~sel, 0, 0, '{8'h00});
      i_host.put_byte(8'h07);
      i_host.hold(4 * TO);
      chk("two-wire waits", 1, awake);
      wait_flag(1'b0, awake, WD);
      chk("watchdog sleep", 0, awake);
      two_wire = 1'b0;
      i_host.wake();
      i_host.put_byte(8'h07);
      wait_flag(1'b0, awake, TO + 20);
      chk("timeout sleep", 0, awake);
      give_verdict();
   end
endmodule : secure_chip_command_front_end_tb
`default_nettype wire
